// [pdt_pkg.sv]
// Constants and types shared by the periodic timer files.
// Assumes a single system clock; every field sits in 8-bit registers.
package pdt_pkg;
    // Register addresses
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_RUN = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h1;
    localparam logic [3:0] ADDR_CNT_L = 4'h2;
    localparam logic [3:0] ADDR_CNT_H = 4'h3;
    localparam logic [3:0] ADDR_CMPA_L = 4'h4;
    localparam logic [3:0] ADDR_CMPA_H = 4'h5;
    localparam logic [3:0] ADDR_PER_L = 4'h6;
    localparam logic [3:0] ADDR_PER_H = 4'h7;
    localparam logic [3:0] ADDR_FLAGS = 4'h8;
    // Reset values and masks
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] RUN_MASK = 8'hF8;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [9:0] CNT_MAX = 10'h3FF;
    localparam logic [9:0] CNT_ONE = 10'h001;
    // Field positions
    localparam int RC_PAUSE = 7;
    localparam int RC_CKS = 4;
    localparam int RC_ON = 3;
    localparam int MC_MODE = 6;
    localparam int MC_PF = 4;
    localparam int MC_OC = 3;
    localparam int MC_POL = 2;
    localparam int MC_CAPS = 1;
    localparam int MC_CLR = 0;
    localparam int FL_A = 0;
    localparam int FL_P = 1;
    // Operating modes
    typedef enum logic [1:0] {
        PDT_CMP = 2'h0,
        PDT_CAP = 2'h1,
        PDT_PWM = 2'h2,
        PDT_TC = 2'h3
    } pdt_mode_t;
    // Pin function codes per mode
    localparam logic [1:0] CM_NONE = 2'h0;
    localparam logic [1:0] CM_LOW = 2'h1;
    localparam logic [1:0] CM_HIGH = 2'h2;
    localparam logic [1:0] CM_TOG = 2'h3;
    localparam logic [1:0] PW_INACT = 2'h0;
    localparam logic [1:0] PW_ACT = 2'h1;
    localparam logic [1:0] PW_WAVE = 2'h2;
    localparam logic [1:0] PW_SINGLE = 2'h3;
    localparam logic [1:0] CP_RISE = 2'h0;
    localparam logic [1:0] CP_FALL = 2'h1;
    localparam logic [1:0] CP_BOTH = 2'h2;
    // Clock select codes
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_SUB0 = 3'h4;
    localparam logic [2:0] CK_SUB1 = 3'h5;
    localparam logic [2:0] CK_EXTR = 3'h6;
    localparam logic [2:0] CK_EXTF = 3'h7;
    // Prescaler terminal masks
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV16_MASK = 6'h0F;
    localparam logic [5:0] DIV64_MASK = 6'h3F;
    localparam logic [5:0] PRE_ONE = 6'h01;
    localparam logic [2:0] SYNC_ZERO = 3'h0;
endpackage

// [pdt_tick.sv]
// Count-enable generator: prescaler, pin synchronisers and edge pulses.
// Assumes the high clock equals the system clock; pins are asynchronous.
`timescale 1ns/1ps
module pdt_tick (
    input wire logic ref_clk_in, // System clock
    input wire logic rst_b_in, // Synchronous reset, active low
    input wire logic [2:0] clk_sel_in, // Clock select field
    input wire logic cap_src_in, // Capture source bit
    input wire logic ext_clock_pin_in, // External clock pin
    input wire logic capture_input_pin_in, // Capture input pin
    input wire logic sub_clock_in, // Sub clock
    output logic tick_out, // One-cycle count enable
    output logic cap_rise_out, // Capture source rising edge
    output logic cap_fall_out // Capture source falling edge
);
    import pdt_pkg::*;

    logic [5:0] pre;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [2:0] rise;
    logic [2:0] fall;
    logic cap_r;
    logic cap_f;

    // Free-running prescaler
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            pre <= 6'h00;
        end else begin
            pre <= pre + PRE_ONE;
        end
    end

    // Two-flop synchronisers: 0 ext clock, 1 capture pin, 2 sub clock
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            sync1 <= SYNC_ZERO;
            sync2 <= SYNC_ZERO;
            prev <= SYNC_ZERO;
        end else begin
            sync1 <= {sub_clock_in, capture_input_pin_in, ext_clock_pin_in};
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // Edge pulses taken after the second flop
    assign rise = sync2 & ~prev;
    assign fall = ~sync2 & prev;
    assign cap_r = cap_src_in ? rise[0] : rise[1];
    assign cap_f = cap_src_in ? fall[0] : fall[1];

    // Clock source multiplexer, registered
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            tick_out <= 1'b0;
            cap_rise_out <= 1'b0;
            cap_fall_out <= 1'b0;
        end else begin
            cap_rise_out <= cap_r;
            cap_fall_out <= cap_f;
            case (clk_sel_in)
                CK_SYS4: tick_out <= (pre & DIV4_MASK) == DIV4_MASK;
                CK_SYS: tick_out <= 1'b1;
                CK_H16: tick_out <= (pre & DIV16_MASK) == DIV16_MASK;
                CK_H64: tick_out <= (pre & DIV64_MASK) == DIV64_MASK;
                CK_SUB0, CK_SUB1: tick_out <= rise[2];
                CK_EXTR: tick_out <= rise[0];
                CK_EXTF: tick_out <= fall[0];
                default: tick_out <= 1'b0;
            endcase
        end
    end
endmodule // pdt_tick

// [pdt_timer.sv]
// Periodic 10-bit timer: registers, counter, comparators, pin logic.
// Assumes a one-cycle read/write strobe port from the system bus.
`timescale 1ns/1ps
module pdt_timer (
    input wire logic ref_clk_in, // System clock, 125 MHz
    input wire logic rst_b_in, // Synchronous reset, active low
    input wire logic [pdt_pkg::ADDR_W-1:0] addr_in, // Register address
    input wire logic [7:0] wr_data_in, // Write data
    input wire logic wr_stb_in, // Write strobe
    input wire logic rd_stb_in, // Read strobe
    output logic [7:0] rd_data_out, // Read data, next cycle
    input wire logic ext_clock_pin_in, // External clock pin
    input wire logic capture_input_pin_in, // Capture input pin
    input wire logic sub_clock_in, // Sub clock input
    output logic timer_output_pin_out, // Timer output pin level
    output logic timer_output_oe_out, // Timer output pin enable
    output logic compare_a_flag_out, // Comparator A flag
    output logic compare_p_flag_out // Comparator P flag
);
    import pdt_pkg::*;

    logic [7:0] run_ctl;
    logic [7:0] mode_ctl;
    logic [9:0] cnt;
    logic [9:0] cmpa;
    logic [9:0] period;
    logic on_q;
    logic out_level;
    logic tick;
    logic cap_rise;
    logic cap_fall;

    logic pause;
    logic [2:0] cks;
    logic on;
    pdt_mode_t mode;
    logic [1:0] pf;
    logic oc;
    logic pol;
    logic cap_src;
    logic clr_sel;

    logic on_rise;
    logic run;
    logic cnt_ev;
    logic hit_a;
    logic hit_p;
    logic clr_by_a;
    logic sp_mode;
    logic cap_edge;
    logic cap_fire;
    logic set_a;
    logic set_p;
    logic cnt_clr;
    logic next_level;
    logic [7:0] next_rd;

    // Field decode of the control registers
    assign pause = run_ctl[RC_PAUSE];
    assign cks = run_ctl[RC_CKS +: 3];
    assign on = run_ctl[RC_ON];
    assign mode = pdt_mode_t'(mode_ctl[MC_MODE +: 2]);
    assign pf = mode_ctl[MC_PF +: 2];
    assign oc = mode_ctl[MC_OC];
    assign pol = mode_ctl[MC_POL];
    assign cap_src = mode_ctl[MC_CAPS];
    assign clr_sel = mode_ctl[MC_CLR];

    // Clock source and capture pin conditioning
    pdt_tick u_tick (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .clk_sel_in(cks),
        .cap_src_in(cap_src),
        .ext_clock_pin_in(ext_clock_pin_in),
        .capture_input_pin_in(capture_input_pin_in),
        .sub_clock_in(sub_clock_in),
        .tick_out(tick),
        .cap_rise_out(cap_rise),
        .cap_fall_out(cap_fall)
    );

    // Run control and comparator events
    assign on_rise = on && !on_q;
    assign run = on && !pause && !on_rise;
    assign cnt_ev = run && tick;
    assign hit_a = cnt_ev && (cnt == cmpa);
    assign hit_p = cnt_ev && ((period == CNT_ZERO) ? (cnt == CNT_MAX) : (cnt == period));
    assign clr_by_a = clr_sel && (mode == PDT_CMP || mode == PDT_TC);
    assign sp_mode = (mode == PDT_PWM) && (pf == PW_SINGLE);

    // Capture trigger selection
    always_comb begin
        case (pf)
            CP_RISE: cap_edge = cap_rise;
            CP_FALL: cap_edge = cap_fall;
            CP_BOTH: cap_edge = cap_rise || cap_fall;
            default: cap_edge = 1'b0;
        endcase
    end
    assign cap_fire = (mode == PDT_CAP) && on && cap_edge;

    // Flag set conditions
    assign set_a = (mode == PDT_CAP) ? cap_fire : hit_a;
    assign set_p = hit_p && !clr_by_a && !sp_mode;
    assign cnt_clr = clr_by_a ? hit_a : (hit_p && !sp_mode);

    // Edge detector for the on/off bit
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            on_q <= 1'b0;
        end else begin
            on_q <= on;
        end
    end

    // Counter
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            cnt <= CNT_ZERO;
        end else if (on_rise) begin
            cnt <= CNT_ZERO;
        end else if (cnt_ev) begin
            if (cnt_clr) begin
                cnt <= CNT_ZERO;
            end else begin
                cnt <= cnt + CNT_ONE;
            end
        end
    end

    // Run control register; compare-A match ends a single pulse
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            run_ctl <= REG_RESET;
        end else if (sp_mode && hit_a) begin
            run_ctl[RC_ON] <= 1'b0;
        end else if (wr_stb_in && addr_in == ADDR_RUN) begin
            run_ctl <= wr_data_in & RUN_MASK;
        end
    end

    // Mode control register
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            mode_ctl <= REG_RESET;
        end else if (wr_stb_in && addr_in == ADDR_MODE) begin
            mode_ctl <= wr_data_in;
        end
    end

    // Compare-A value; a capture overrides a same-cycle write
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            cmpa <= CNT_ZERO;
        end else if (cap_fire) begin
            cmpa <= cnt;
        end else if (wr_stb_in && addr_in == ADDR_CMPA_L) begin
            cmpa[7:0] <= wr_data_in;
        end else if (wr_stb_in && addr_in == ADDR_CMPA_H) begin
            cmpa[9:8] <= wr_data_in[1:0];
        end
    end

    // Period value
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            period <= CNT_ZERO;
        end else if (wr_stb_in && addr_in == ADDR_PER_L) begin
            period[7:0] <= wr_data_in;
        end else if (wr_stb_in && addr_in == ADDR_PER_H) begin
            period[9:8] <= wr_data_in[1:0];
        end
    end

    // Flags: write one to clear, a set in the same cycle wins
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            compare_a_flag_out <= 1'b0;
            compare_p_flag_out <= 1'b0;
        end else begin
            if (set_a) begin
                compare_a_flag_out <= 1'b1;
            end else if (wr_stb_in && addr_in == ADDR_FLAGS && wr_data_in[FL_A]) begin
                compare_a_flag_out <= 1'b0;
            end
            if (set_p) begin
                compare_p_flag_out <= 1'b1;
            end else if (wr_stb_in && addr_in == ADDR_FLAGS && wr_data_in[FL_P]) begin
                compare_p_flag_out <= 1'b0;
            end
        end
    end

    // Next internal pin level per mode
    always_comb begin
        next_level = out_level;
        case (mode)
            PDT_CMP: begin
                if (on_rise) begin
                    next_level = oc;
                end else if (hit_a) begin
                    case (pf)
                        CM_LOW: next_level = 1'b0;
                        CM_HIGH: next_level = 1'b1;
                        CM_TOG: next_level = ~out_level;
                        default: next_level = out_level;
                    endcase
                end
            end
            PDT_PWM: begin
                case (pf)
                    PW_INACT: next_level = ~oc;
                    PW_ACT: next_level = oc;
                    PW_WAVE: next_level = (cnt < cmpa) ? oc : ~oc;
                    default: next_level = on ? oc : ~oc;
                endcase
            end
            default: next_level = out_level;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            out_level <= 1'b0;
        end else begin
            out_level <= next_level;
        end
    end

    // Pin drive: polarity applied, undriven in capture and timer modes
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            timer_output_pin_out <= 1'b0;
            timer_output_oe_out <= 1'b0;
        end else begin
            timer_output_pin_out <= out_level ^ pol;
            timer_output_oe_out <= (mode == PDT_CMP) || (mode == PDT_PWM);
        end
    end

    // Read multiplexer
    always_comb begin
        case (addr_in)
            ADDR_RUN: next_rd = run_ctl;
            ADDR_MODE: next_rd = mode_ctl;
            ADDR_CNT_L: next_rd = cnt[7:0];
            ADDR_CNT_H: next_rd = {6'h00, cnt[9:8]};
            ADDR_CMPA_L: next_rd = cmpa[7:0];
            ADDR_CMPA_H: next_rd = {6'h00, cmpa[9:8]};
            ADDR_PER_L: next_rd = period[7:0];
            ADDR_PER_H: next_rd = {6'h00, period[9:8]};
            ADDR_FLAGS: next_rd = {6'h00, compare_p_flag_out, compare_a_flag_out};
            default: next_rd = 8'h00;
        endcase
    end

    // Read data stands for the one cycle after the strobe
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_stb_in) begin
            rd_data_out <= next_rd;
        end else begin
            rd_data_out <= 8'h00;
        end
    end

    // Checks on the timer behaviour
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_read_high: assert property (
        rd_stb_in && addr_in == ADDR_CNT_H |=> rd_data_out == {6'h00, $past(cnt[9:8])}
    ) else $error("count high readback wrong");

    a_pause_hold: assert property (
        pause && on && !on_rise |=> cnt == $past(cnt)
    ) else $error("counter moved while paused");

    a_on_clear: assert property (
        on_rise |=> cnt == CNT_ZERO
    ) else $error("on rise did not clear counter");

    a_off_hold: assert property (
        !on |=> cnt == $past(cnt)
    ) else $error("counter moved while off");

    a_init_level: assert property (
        mode == PDT_CMP && on_rise && $stable(pol) |=> ##1
            timer_output_pin_out == ($past(oc, 2) ^ pol)
    ) else $error("initial pin level not restored");

    a_no_pflag: assert property (
        clr_by_a && !compare_p_flag_out |=> !compare_p_flag_out || (mode != PDT_CMP && mode != PDT_TC)
            || !$past(clr_by_a)
    ) else $error("P flag raised under clear by A");

    a_flag_set: assert property (
        set_a |=> compare_a_flag_out
    ) else $error("A flag not set on match");

    a_tc_undriven: assert property (
        mode == PDT_TC |=> !timer_output_oe_out
    ) else $error("pin driven in timer mode");

    a_cap_load: assert property (
        cap_fire |=> cmpa == $past(cnt)
    ) else $error("capture did not load count");

    a_period_clr: assert property (
        hit_p && !clr_by_a && !sp_mode |=> cnt == CNT_ZERO
    ) else $error("period match did not clear");

    c_on_rise: cover property (on_rise);
    c_cmp_match: cover property (mode == PDT_CMP && hit_a);
    c_capture: cover property (cap_fire);
    c_overflow: cover property (hit_p && period == CNT_ZERO);
endmodule // pdt_timer

// [pdt_pins_model.sv]
// Far-side pin model for the periodic timer: sub clock, external clock and capture pins.
// Assumes the system clock of the bench; all pins are push-pull levels.
`timescale 1ns/1ps
module pdt_pins_model (
    input wire logic ref_clk_in, // System clock
    input wire logic rst_b_in, // Synchronous reset, active low
    input wire logic cap_level_in, // Capture level asked by the bench
    output logic sub_clock_out, // Sub clock, period 12 system cycles
    output logic ext_clock_pin_out, // External clock pin, period 40 system cycles
    output logic capture_pin_out // Capture input pin
);
    logic [4:0] sub_cnt;
    logic [4:0] ext_cnt;
    // Free-running sub oscillator, independent of the timer state
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            sub_cnt <= 5'h00;
            sub_clock_out <= 1'b0;
        end else begin
            sub_cnt <= (sub_cnt == 5'h05) ? 5'h00 : sub_cnt + 5'h01;
            sub_clock_out <= (sub_cnt == 5'h05) ? ~sub_clock_out : sub_clock_out;
        end
    end
    // External clock pin toggles every 20 cycles
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            ext_cnt <= 5'h00;
            ext_clock_pin_out <= 1'b0;
        end else begin
            ext_cnt <= (ext_cnt == 5'h13) ? 5'h00 : ext_cnt + 5'h01;
            ext_clock_pin_out <= (ext_cnt == 5'h13) ? ~ext_clock_pin_out : ext_clock_pin_out;
        end
    end
    // Capture pin follows the level the bench asks for
    assign capture_pin_out = cap_level_in;
endmodule // pdt_pins_model

// [pdt_timer_tb.sv]
// Self-checking bench for the periodic timer: registers, counting, pin and capture.
// Assumes pdt_pkg and the pin model are compiled first; one 125 MHz clock.
`timescale 1ns/1ps
module pdt_timer_tb;
    import pdt_pkg::*;
    logic ref_clk, rst_b, wr_stb, rd_stb, cap_level, ext_pin, cap_pin, sub_clk;
    logic pin, oe, flag_a, flag_p, e;
    logic [3:0] addr;
    logic [7:0] wr_data, rd_data, d1, d2, d3;
    int errors, checks, mx, hi_n;
    int lo_t [8] = '{125, 500, 30, 7, 40, 40, 11, 11};
    int hi_t [8] = '{130, 516, 33, 9, 45, 45, 14, 14};

    pdt_timer pdt_timer_i (.ref_clk_in(ref_clk), .rst_b_in(rst_b), .addr_in(addr),
        .wr_data_in(wr_data), .wr_stb_in(wr_stb), .rd_stb_in(rd_stb), .rd_data_out(rd_data),
        .ext_clock_pin_in(ext_pin), .capture_input_pin_in(cap_pin), .sub_clock_in(sub_clk),
        .timer_output_pin_out(pin), .timer_output_oe_out(oe), .compare_a_flag_out(flag_a),
        .compare_p_flag_out(flag_p));
    pdt_pins_model pdt_pins_model_i (.ref_clk_in(ref_clk), .rst_b_in(rst_b),
        .cap_level_in(cap_level), .sub_clock_out(sub_clk), .ext_clock_pin_out(ext_pin),
        .capture_pin_out(cap_pin));

    // 125 MHz system clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Bus cycles, waits and comparisons
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        d = rd_data;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rng(input string nm, input int lo, input int hi, input logic [9:0] got);
        checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            errors++;
            $display("mismatch %s expected %0d..%0d seen %h", nm, lo, hi, got);
        end
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] x);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("register %h", a), {2'b00, x}, {2'b00, d});
    endtask
    task automatic final_report;
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_flags(input logic [1:0] want, input int lim);
        int n;
        n = 0;
        while ((({flag_p, flag_a} & want) !== want) && n < lim) begin
            cyc(1);
            n++;
        end
        checks++;
        if (n >= lim) begin
            errors++;
            $display("mismatch flags expected %b seen %b", want, {flag_p, flag_a});
            final_report();
        end
    endtask
    // Timer off before the mode changes, flags cleared, then the run value
    task automatic start(input logic [7:0] mode, input logic [7:0] run);
        wr(ADDR_RUN, 8'h00);
        wr(ADDR_MODE, mode);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_RUN, run);
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 4'h0;
        wr_data = 8'h00;
        cap_level = 1'b0;
        errors = 0;
        checks = 0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 16; a++) rdchk(a[3:0], 8'h00);
        wr(ADDR_CMPA_L, 8'hFF);
        wr(ADDR_CMPA_H, 8'hFF);
        wr(ADDR_PER_L, 8'hA5);
        wr(ADDR_PER_H, 8'hFE);
        wr(ADDR_RUN, 8'h07);
        wr(ADDR_CNT_H, 8'hFF);
        wr(4'hF, 8'hFF);
        rdchk(ADDR_CMPA_L, 8'hFF);
        rdchk(ADDR_CMPA_H, 8'h03);
        rdchk(ADDR_PER_L, 8'hA5);
        rdchk(ADDR_PER_H, 8'h02);
        rdchk(ADDR_RUN, 8'h00);
        rdchk(ADDR_CNT_H, 8'h00);
        rdchk(4'hF, 8'h00);
        // Compare output: every pin function with both initial levels, period below A
        wr(ADDR_CMPA_L, 8'h0A);
        wr(ADDR_CMPA_H, 8'h00);
        wr(ADDR_PER_L, 8'h03);
        wr(ADDR_PER_H, 8'h00);
        for (int oc = 0; oc < 2; oc++) begin
            for (int pf = 0; pf < 4; pf++) begin
                start({2'b00, pf[1:0], oc[0], 3'b001}, 8'h18);
                cyc(3);
                chk("pin initial", {9'h000, oc[0]}, {9'h000, pin});
                chk("pin enable", 10'h001, {9'h000, oe});
                wait_flags(2'b01, 40);
                cyc(3);
                e = (pf == 0) ? oc[0] : (pf == 3) ? ~oc[0] : pf[1];
                chk("pin after match", {9'h000, e}, {9'h000, pin});
                chk("flag p", 10'h000, {9'h000, flag_p});
            end
        end
        start(8'h25, 8'h18);
        cyc(3);
        chk("pin inverted", 10'h001, {9'h000, pin});
        wait_flags(2'b01, 40);
        cyc(3);
        chk("pin inverted match", 10'h000, {9'h000, pin});
        // Period clear: both flags, count passes A and stays within the period
        wr(ADDR_PER_L, 8'h14);
        start(8'h30, 8'h18);
        wait_flags(2'b11, 64);
        rdchk(ADDR_FLAGS, 8'h03);
        mx = 0;
        repeat (12) begin
            rd(ADDR_CNT_L, d1);
            mx = (d1 > mx) ? d1 : mx;
        end
        rng("count max", 11, 20, mx[9:0]);
        // Pause, off and restart in timer mode
        wr(ADDR_PER_L, 8'h00);
        start(8'hC0, 8'h18);
        cyc(300);
        chk("timer mode enable", 10'h000, {9'h000, oe});
        wr(ADDR_RUN, 8'h98);
        cyc(2);
        rd(ADDR_CNT_L, d1);
        rd(ADDR_CNT_H, d2);
        chk("count high", 10'h001, {2'b00, d2});
        cyc(10);
        rd(ADDR_CNT_L, d3);
        chk("count paused", {2'b00, d1}, {2'b00, d3});
        wr(ADDR_RUN, 8'h18);
        cyc(10);
        rd(ADDR_CNT_L, d3);
        rng("count resumed", d1 + 8, d1 + 16, {2'b00, d3});
        wr(ADDR_RUN, 8'h10);
        rd(ADDR_CNT_L, d1);
        cyc(10);
        rd(ADDR_CNT_L, d3);
        chk("count held off", {2'b00, d1}, {2'b00, d3});
        wr(ADDR_RUN, 8'h18);
        rd(ADDR_CNT_L, d3);
        rng("count restart", 0, 4, {2'b00, d3});
        // All-zero period: only the overflow after 0x3FF clears and raises P
        start(8'hC0, 8'h18);
        cyc(1000);
        chk("flag p before overflow", 10'h000, {9'h000, flag_p});
        wait_flags(2'b10, 40);
        rdchk(ADDR_CNT_H, 8'h00);
        // Every clock source over a fixed span
        for (int ck = 0; ck < 8; ck++) begin
            start(8'hC0, {1'b0, ck[2:0], 4'h8});
            cyc(512);
            wr(ADDR_RUN, {1'b1, ck[2:0], 4'h8});
            rd(ADDR_CNT_L, d1);
            rd(ADDR_CNT_H, d2);
            rng("count per source", lo_t[ck], hi_t[ck], {d2[1:0], d1});
        end
        // Capture edges from the capture pin while the clock pin keeps toggling, then from the clock pin
        for (int pf = 0; pf < 4; pf++) begin
            start({2'b01, pf[1:0], 4'h0}, 8'h18);
            cyc(4);
            chk("capture enable", 10'h000, {9'h000, oe});
            @(posedge ref_clk);
            cap_level <= 1'b1;
            cyc(45);
            chk("capture rise", {9'h000, pf == 0 || pf == 2}, {9'h000, flag_a});
            wr(ADDR_FLAGS, 8'h01);
            @(posedge ref_clk);
            cap_level <= 1'b0;
            cyc(45);
            chk("capture fall", {9'h000, pf == 1 || pf == 2}, {9'h000, flag_a});
        end
        start(8'h42, 8'h18);
        cyc(45);
        chk("capture from clock pin", 10'h001, {9'h000, flag_a});
        // Forced levels and waveform, active high
        wr(ADDR_CMPA_L, 8'h05);
        wr(ADDR_PER_L, 8'h14);
        for (int pf = 0; pf < 3; pf++) begin
            start({2'b10, pf[1:0], 4'h8}, 8'h18);
            cyc(4);
            hi_n = 0;
            repeat (84) begin
                cyc(1);
                hi_n += (pin === 1'b1);
            end
            rng("pwm high", (pf == 2) ? 15 : 84 * pf, (pf == 2) ? 28 : 84 * pf, hi_n[9:0]);
        end
        // Single pulse ends at the A match and drops the on bit
        start(8'hB8, 8'h18);
        cyc(3);
        chk("pulse active", 10'h001, {9'h000, pin});
        wait_flags(2'b01, 40);
        cyc(3);
        rdchk(ADDR_RUN, 8'h10);
        chk("pulse ended", 10'h000, {9'h000, pin});
        final_report();
    end
endmodule // pdt_timer_tb
